// File: dv/csss_top_asserts.sv
// Concurrent checks on the ports of the clock source start-up selector
`timescale 1ns/1ps
module csss_top_asserts #(
   parameter int RT_LONG_CYC = 8192,
   parameter int WAKE_16K    = 16384
) (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        SLEEP_REQ,
   input wire logic [7:0]  OSC_TRIM,
   input wire logic        RC_OSC_SEL,
   input wire logic        WDT_OSC_SEL,
   input wire logic        XTAL_EN,
   input wire logic [2:0]  XTAL_MODE,
   input wire logic        WDT_OSC_EN,
   input wire logic        CPU_RUN
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // ----------------------------------------
   // Bus cycle steps
   // ----------------------------------------
   sequence s_req;
      CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_trim_wr;
      s_req ##0 (WB_WE_I && WB_ADR_I == csss_pkg::ADR_TRIM && WB_SEL_I[0]) ##1 (CE && WB_ACK_O);
   endsequence
   sequence s_gap_rd;
      s_req ##0 (!WB_WE_I && WB_ADR_I > csss_pkg::ADR_COUNT) ##1 WB_ACK_O;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_ACK_NEXT: assert property (s_req |=> WB_ACK_O) else $error("ack late");
   AST_ACK_PULSE: assert property (CE && WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
   AST_TRIM_WR: assert property (s_trim_wr |=> OSC_TRIM == $past(WB_DAT_I[7:0])) else $error("trim");
   AST_GAP_RD: assert property (s_gap_rd |-> WB_DAT_O == 32'h0) else $error("gap read");
   AST_SRC_ONE: assert property ($onehot0({RC_OSC_SEL, WDT_OSC_SEL, XTAL_EN})) else $error("src");
   AST_XMODE: assert property (XTAL_MODE != 3'h0 |-> XTAL_EN && XTAL_MODE[2]) else $error("mode");
   AST_WDT_ON: assert property (WDT_OSC_EN) else $error("wdt osc off");
   AST_RST_OUT: assert property ($fell(RST) |-> OSC_TRIM == csss_pkg::TRIM_RST && RC_OSC_SEL) else $error("rst");
   AST_RUN_LATE: assert property ($fell(RST) |-> !CPU_RUN [*8]) else $error("run early");
   AST_SLEEP: assert property (CE && SLEEP_REQ && CPU_RUN |=> !CPU_RUN) else $error("sleep");
endmodule
bind csss_top csss_top_asserts #(.RT_LONG_CYC(RT_LONG_CYC), .WAKE_16K(WAKE_16K)) u_csss_top_asserts (
   .MCLK(MCLK), .RST(RST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .SLEEP_REQ(SLEEP_REQ), .OSC_TRIM(OSC_TRIM), .RC_OSC_SEL(RC_OSC_SEL),
   .WDT_OSC_SEL(WDT_OSC_SEL), .XTAL_EN(XTAL_EN), .XTAL_MODE(XTAL_MODE), .WDT_OSC_EN(WDT_OSC_EN),
   .CPU_RUN(CPU_RUN));

// File: dv/csss_top_bench.sv
// Self-checking bench of the clock source start-up selector
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module csss_top_bench;
   localparam int RT_L = 40;
   localparam int W16  = 50;
   // Lowest crystal mode row (8'h28) stands for a ceramic resonator, never a quartz crystal
   localparam logic [7:0] ROW_SEL [6] = '{8'h03, 8'h12, 8'h28, 8'h0B, 8'h1D, 8'h0E};
   localparam logic [5:0] ROW_DEC [6] = '{6'h10, 6'h20, 6'h0C, 6'h0D, 6'h0E, 6'h0F};
   localparam int         ROW_WK  [6] = '{6, 6, 1024, 1024, W16, 258};
   logic        MCLK, RST = 1'b1, CE = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [7:0]  WB_ADR_I = 8'h00, FACTORY_TRIM = 8'hA5, OSC_TRIM;
   logic [3:0]  WB_SEL_I = 4'h0, CLK_SRC_FUSE = 4'h2;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
   logic [1:0]  STARTUP_FUSE = 2'h2;
   logic        RESET_PIN_DISABLE_FUSE = 1'b0, DIV_BY_EIGHT_FUSE = 1'b0, SLEEP_REQ = 1'b0, WAKE_REQ = 1'b0;
   logic        WB_ACK_O, RC_OSC_SEL, WDT_OSC_SEL, XTAL_EN, WDT_OSC_EN, DIV8_EN, CPU_RUN, osc_q = 1'b0;
   logic [2:0]  XTAL_MODE, div_q = 3'h0;
   int          n_fail = 0, n_compared = 0, ticks = 0;
   csss_top #(.RT_LONG_CYC(RT_L), .WAKE_16K(W16)) u_csss_top (
      .MCLK(MCLK), .RST(RST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
      .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O), .CLK_SRC_FUSE(CLK_SRC_FUSE), .STARTUP_FUSE(STARTUP_FUSE),
      .RESET_PIN_DISABLE_FUSE(RESET_PIN_DISABLE_FUSE), .DIV_BY_EIGHT_FUSE(DIV_BY_EIGHT_FUSE),
      .FACTORY_TRIM(FACTORY_TRIM), .WDT_OSC_CLK(osc_q), .SRC_OSC_CLK(osc_q), .SLEEP_REQ(SLEEP_REQ),
      .WAKE_REQ(WAKE_REQ), .OSC_TRIM(OSC_TRIM), .RC_OSC_SEL(RC_OSC_SEL), .WDT_OSC_SEL(WDT_OSC_SEL),
      .XTAL_EN(XTAL_EN), .XTAL_MODE(XTAL_MODE), .WDT_OSC_EN(WDT_OSC_EN), .DIV8_EN(DIV8_EN),
      .CPU_RUN(CPU_RUN));
   initial begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end
   // Both oscillators share one slow clock, ten MCLK cycles a tick, so ticks are easy to count
   always @(posedge MCLK) begin
      div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
      if (div_q == 3'h4) begin
         osc_q <= ~osc_q;
         ticks <= ticks + int'(!osc_q);
      end
   end
   task automatic tally_and_finish;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Classic single cycle; holds the request until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge MCLK);
      {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'h3, we};
      {WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {adr, dat, sel};
      do begin @(posedge MCLK); n++; end while (WB_ACK_O !== 1'b1 && n < 50);
      if (n >= 50) n_fail++;
      rd = WB_DAT_O;
      {WB_CYC_I, WB_STB_I} <= 2'h0;
   endtask
   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0, 4'hF);
      `CHK(rd, exp)
   endtask
   // Ticks from now until the core runs again; the core must have stopped first
   task automatic wait_run(input int lo, input int hi);
      int n, t0;
      t0 = ticks;
      n = 0;
      repeat (2) @(posedge MCLK);
      `CHK(CPU_RUN, 1'b0)
      while (CPU_RUN !== 1'b1 && n < 20000) begin @(posedge MCLK); n++; end
      `CHK((ticks - t0 >= lo) && (ticks - t0 <= hi), 1'b1)
   endtask
   initial begin
      #400000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge MCLK);
      `CHK({OSC_TRIM, RC_OSC_SEL, CPU_RUN, WDT_OSC_EN, DIV8_EN}, 12'h00A)
      RST <= 1'b0;
      wait_run(RT_L + 13, RT_L + 16);
      `CHK(OSC_TRIM, 8'hA5)
      rdc(csss_pkg::ADR_CLK_SRC_FIELD, 32'h22);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, csss_pkg::ADR_CLK_SRC_FIELD, {24'h0, ROW_SEL[i]}, 4'hF);
         wait_run(ROW_WK[i] - 1, ROW_WK[i] + 1);
         `CHK({RC_OSC_SEL, WDT_OSC_SEL, XTAL_EN, XTAL_MODE}, ROW_DEC[i])
         rdc(csss_pkg::ADR_CLK_SRC_FIELD, {24'h0, ROW_SEL[i]});
      end
      $display("test select table done");
      // Reserved start-up value on the RC source; one edge later the core must still run
      wb(1'b1, csss_pkg::ADR_CLK_SRC_FIELD, 32'h32, 4'hF);
      @(posedge MCLK);
      `CHK(CPU_RUN, 1'b1)
      wb(1'b1, csss_pkg::ADR_CLK_SRC_FIELD, 32'h20, 4'hF);
      rdc(csss_pkg::ADR_CLK_SRC_FIELD, 32'h0E);
      wb(1'b0, csss_pkg::ADR_STAT, 32'h0, 4'hF);
      `CHK(rd[3], 1'b1)
      wb(1'b1, csss_pkg::ADR_STAT, 32'h08, 4'hF);
      rdc(csss_pkg::ADR_STAT, 32'h01);
      wb(1'b1, csss_pkg::ADR_TRIM, 32'h5A, 4'hF);
      wb(1'b1, csss_pkg::ADR_TRIM, 32'h33, 4'hE);
      @(posedge MCLK);
      `CHK(OSC_TRIM, 8'h5A)
      wb(1'b1, 8'h10, 32'hFF, 4'hF);
      rdc(8'h10, 32'h0);
      // Clock enable low must freeze the sequencer against a sleep request
      CE <= 1'b0;
      SLEEP_REQ <= 1'b1;
      repeat (3) @(posedge MCLK);
      CE <= 1'b1;
      SLEEP_REQ <= 1'b0;
      @(posedge MCLK);
      `CHK(CPU_RUN, 1'b1)
      $display("test register edge cases done");
      @(posedge MCLK) SLEEP_REQ <= 1'b1;
      @(posedge MCLK) SLEEP_REQ <= 1'b0;
      rdc(csss_pkg::ADR_STAT, 32'h04);
      repeat (3) @(posedge MCLK);
      WAKE_REQ <= 1'b1;
      wait_run(257, 259);
      WAKE_REQ <= 1'b0;
      rdc(csss_pkg::ADR_COUNT, 32'(csss_pkg::WAKE_258));
      $display("test sleep wake done");
      {CLK_SRC_FUSE, STARTUP_FUSE, RESET_PIN_DISABLE_FUSE, DIV_BY_EIGHT_FUSE} <= 8'h33;
      {FACTORY_TRIM, RST} <= {8'hC3, 1'b1};
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      wait_run(512 + 13, 512 + 16);
      `CHK({OSC_TRIM, WDT_OSC_SEL, DIV8_EN}, 10'h30F)
      rdc(csss_pkg::ADR_STAT, 32'h31);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule

// File: logic/csss_dcnt.sv
// Delay counter: counts ticks from zero up to a loaded target
`timescale 1ns/1ps
module csss_dcnt #(
   parameter int W = 15
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   csss_cnt_if.cnt   cif
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] tgt;
   } csss_dcnt_s;

   csss_dcnt_s c_q;
   csss_dcnt_s c_d;

   // Load restarts from zero; counting stops once the target is met
   always_comb begin
      c_d = c_q;
      if (cif.load) begin
         c_d.cnt = '0;
         c_d.tgt = cif.target;
      end else if (cif.tick && (c_q.cnt < c_q.tgt)) begin
         c_d.cnt = c_q.cnt + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         c_q <= '0;
      end else if (ce) begin
         c_q <= c_d;
      end
   end

   assign cif.done  = (c_q.cnt >= c_q.tgt);
   assign cif.count = c_q.cnt;

endmodule

// File: logic/csss_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module csss_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } csss_sync_s;

   csss_sync_s s_q;
   csss_sync_s s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = d;
      s_d.stab = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stab;

endmodule

// File: logic/csss_top.sv
// Clock source start-up selector: fuse copy, trim load, reset and wake-up delays
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module csss_top #(
   parameter int RT_LONG_CYC = csss_pkg::RT_LONG_CYC,
   parameter int WAKE_16K    = csss_pkg::WAKE_16K
) (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output      logic [31:0] WB_DAT_O,
   output      logic        WB_ACK_O,
   input  wire logic [3:0]  CLK_SRC_FUSE,
   input  wire logic [1:0]  STARTUP_FUSE,
   input  wire logic        RESET_PIN_DISABLE_FUSE,
   input  wire logic        DIV_BY_EIGHT_FUSE,
   input  wire logic [7:0]  FACTORY_TRIM,
   input  wire logic        WDT_OSC_CLK,
   input  wire logic        SRC_OSC_CLK,
   input  wire logic        SLEEP_REQ,
   input  wire logic        WAKE_REQ,
   output      logic [7:0]  OSC_TRIM,
   output      logic        RC_OSC_SEL,
   output      logic        WDT_OSC_SEL,
   output      logic        XTAL_EN,
   output      logic [2:0]  XTAL_MODE,
   output      logic        WDT_OSC_EN,
   output      logic        DIV8_EN,
   output      logic        CPU_RUN
);

   localparam int CW     = csss_pkg::CNT_W;
   localparam int SYNC_W = 18;

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      csss_pkg::csss_state_e st;
      logic [1:0]            fw;
      logic [7:0]            trim;
      logic [3:0]            src;
      logic [1:0]            startup_fuse;
      logic                  rej;
      logic                  rpd;
      logic                  div8;
      logic                  load;
      logic [CW-1:0]         tgt;
      logic                  tsel;
      logic                  wdt_d;
      logic                  src_d;
      logic                  ack;
      logic [31:0]           rdat;
   } csss_top_s;

   localparam csss_top_s RST_VAL = '{
      st:    csss_pkg::S_FUSE,
      fw:    2'h0,
      trim:  csss_pkg::TRIM_RST,
      src:   csss_pkg::SRC_RST,
      startup_fuse:   csss_pkg::SUT_RST,
      rej:   1'b0,
      rpd:   1'b0,
      div8:  1'b0,
      load:  1'b0,
      tgt:   '0,
      tsel:  1'b0,
      wdt_d: 1'b0,
      src_d: 1'b0,
      ack:   1'b0,
      rdat:  32'h00000000
   };

   csss_top_s q;
   csss_top_s d;

   // ----------------------------------------------------------------
   // Decoding of source and start-up fields
   // ----------------------------------------------------------------
   // Returns wake-up class, real-time class and whether the pair is usable
   function automatic csss_pkg::csss_dec_s csss_decode(
      input logic [3:0] s,
      input logic [1:0] u,
      input logic       rpd
   );
      csss_pkg::csss_dec_s r;
      r.valid = 1'b0;
      r.wake  = csss_pkg::W_6;
      r.rt    = csss_pkg::RT_NONE;
      if ((s == csss_pkg::SRC_RC) || (s == csss_pkg::SRC_WDT)) begin
         r.valid = (u != csss_pkg::SUT_RSVD);
         r.wake  = csss_pkg::W_6;
         case (u)
            2'h0:    r.rt = csss_pkg::RT_NONE;
            2'h1:    r.rt = csss_pkg::RT_SHORT;
            default: r.rt = csss_pkg::RT_LONG;
         endcase
      end else if (s[3]) begin
         r.valid = 1'b1;
         case ({s[0], u})
            3'h0, 3'h1:       r.wake = csss_pkg::W_258;
            3'h2, 3'h3, 3'h4: r.wake = csss_pkg::W_1K;
            default:          r.wake = csss_pkg::W_16K;
         endcase
         case ({s[0], u})
            3'h0, 3'h3, 3'h6: r.rt = csss_pkg::RT_SHORT;
            3'h1, 3'h4, 3'h7: r.rt = csss_pkg::RT_LONG;
            default:          r.rt = csss_pkg::RT_NONE;
         endcase
      end
      // Without a reset pin the bare 14-cycle delay is too short to trust
      if (rpd && (r.rt == csss_pkg::RT_NONE)) begin
         r.rt = csss_pkg::RT_SHORT;
      end
      return r;
   endfunction

   // Watchdog ticks for the real-time part of the reset delay
   function automatic logic [CW-1:0] csss_rt_cyc(input csss_pkg::csss_rt_e rt);
      case (rt)
         csss_pkg::RT_SHORT: return CW'(csss_pkg::RT_SHORT_CYC);
         csss_pkg::RT_LONG:  return CW'(RT_LONG_CYC);
         default:            return '0;
      endcase
   endfunction

   // Source ticks for a wake-up delay
   function automatic logic [CW-1:0] csss_wake_cyc(input csss_pkg::csss_wake_e w);
      case (w)
         csss_pkg::W_258: return CW'(csss_pkg::WAKE_258);
         csss_pkg::W_1K:  return CW'(csss_pkg::WAKE_1K);
         csss_pkg::W_16K: return CW'(WAKE_16K);
         default:         return CW'(csss_pkg::WAKE_SHORT);
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync_q;
   logic [3:0]        fz_src;
   logic [1:0]        fz_sut;
   logic              fz_rpd;
   logic              fz_div8;
   logic [7:0]        fz_trim;
   logic              wdt_s;
   logic              src_s;

   // Fuses, trim and both oscillator clocks come from outside this domain
   csss_sync #(
      .W (SYNC_W)
   ) u_sync (
      .clk (MCLK),
      .rst (RST),
      .ce  (CE),
      .d   ({SRC_OSC_CLK, WDT_OSC_CLK, FACTORY_TRIM, DIV_BY_EIGHT_FUSE,
             RESET_PIN_DISABLE_FUSE, STARTUP_FUSE, CLK_SRC_FUSE}),
      .q   (sync_q)
   );

   assign fz_src  = sync_q[3:0];
   assign fz_sut  = sync_q[5:4];
   assign fz_rpd  = sync_q[6];
   assign fz_div8 = sync_q[7];
   assign fz_trim = sync_q[15:8];
   assign wdt_s   = sync_q[16];
   assign src_s   = sync_q[17];

   // ----------------------------------------------------------------
   // Delay counter
   // ----------------------------------------------------------------
   csss_cnt_if #(.W (CW)) cif ();

   csss_dcnt #(
      .W (CW)
   ) u_dcnt (
      .clk (MCLK),
      .rst (RST),
      .ce  (CE),
      .cif (cif)
   );

   logic wdt_rise;
   logic src_rise;

   // Watchdog ticks drive the real-time part whatever source is selected
   assign wdt_rise   = wdt_s & ~q.wdt_d;
   assign src_rise   = src_s & ~q.src_d;
   assign cif.load   = q.load;
   assign cif.target = q.tgt;
   assign cif.tick   = q.tsel ? wdt_rise : src_rise;

   // ----------------------------------------------------------------
   // Decoded views
   // ----------------------------------------------------------------
   csss_pkg::csss_dec_s cur_dec;
   csss_pkg::csss_dec_s fuse_dec;
   csss_pkg::csss_dec_s wr_dec;
   csss_pkg::csss_dec_s dflt_dec;
   logic                bus_req;
   logic                bus_wr;
   logic [31:0]         rd_mux;

   assign cur_dec  = csss_decode(q.src, q.startup_fuse, q.rpd);
   assign fuse_dec = csss_decode(fz_src, fz_sut, fz_rpd);
   assign dflt_dec = csss_decode(csss_pkg::SRC_RST, csss_pkg::SUT_RST, fz_rpd);
   assign wr_dec   = csss_decode(WB_DAT_I[csss_pkg::CLK_SRC_FIELD_SRC_LSB +: 4],
                                 WB_DAT_I[csss_pkg::CLK_SRC_FIELD_SUT_LSB +: 2], q.rpd);
   assign bus_req  = WB_CYC_I & WB_STB_I;
   // A write lands on the edge at which the master sees the acknowledge
   assign bus_wr   = bus_req & WB_WE_I & q.ack & WB_SEL_I[0];

   // Read data multiplexer, unmapped words read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (WB_ADR_I)
         csss_pkg::ADR_TRIM: begin
            rd_mux[7:0] = q.trim;
         end
         csss_pkg::ADR_CLK_SRC_FIELD: begin
            rd_mux[csss_pkg::CLK_SRC_FIELD_SRC_LSB +: 4] = q.src;
            rd_mux[csss_pkg::CLK_SRC_FIELD_SUT_LSB +: 2] = q.startup_fuse;
         end
         csss_pkg::ADR_STAT: begin
            rd_mux[csss_pkg::STAT_RUN_BIT]  = (q.st == csss_pkg::S_RUN);
            rd_mux[csss_pkg::STAT_BUSY_BIT] = (q.st != csss_pkg::S_RUN) && (q.st != csss_pkg::S_SLEEP);
            rd_mux[csss_pkg::STAT_SLP_BIT]  = (q.st == csss_pkg::S_SLEEP);
            rd_mux[csss_pkg::STAT_REJ_BIT]  = q.rej;
            rd_mux[csss_pkg::STAT_RPD_BIT]  = q.rpd;
            rd_mux[csss_pkg::STAT_DIV8_BIT] = q.div8;
         end
         csss_pkg::ADR_COUNT: begin
            rd_mux[CW-1:0] = cif.count;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer and register file
   // ----------------------------------------------------------------
   always_comb begin
      d       = q;
      d.load  = 1'b0;
      d.ack   = 1'b0;
      d.wdt_d = wdt_s;
      d.src_d = src_s;

      // Bus answer one cycle after the request, dropped the cycle after
      if (bus_req && !q.ack) begin
         d.ack  = 1'b1;
         d.rdat = rd_mux;
      end

      // Start-up sequence
      case (q.st)
         csss_pkg::S_FUSE: begin
            d.fw = q.fw + 2'h1;
            // Wait for the synchronisers to fill before trusting the fuses
            if (q.fw == 2'(csss_pkg::FUSE_WAIT)) begin
               d.trim = fz_trim;
               d.rpd  = fz_rpd;
               d.div8 = fz_div8;
               d.st   = csss_pkg::S_RST_RT;
               d.load = 1'b1;
               d.tsel = 1'b1;
               if (fuse_dec.valid) begin
                  d.src = fz_src;
                  d.startup_fuse = fz_sut;
                  d.tgt = csss_rt_cyc(fuse_dec.rt);
               end else begin
                  d.tgt = csss_rt_cyc(dflt_dec.rt);
               end
            end
         end
         csss_pkg::S_RST_RT: begin
            if (!q.load && cif.done) begin
               d.st   = csss_pkg::S_RST_CK;
               d.load = 1'b1;
               d.tsel = 1'b0;
               d.tgt  = CW'(csss_pkg::RST_CK_CYC);
            end
         end
         csss_pkg::S_RST_CK: begin
            if (!q.load && cif.done) begin
               d.st = csss_pkg::S_RUN;
            end
         end
         csss_pkg::S_RUN: begin
            if (SLEEP_REQ) begin
               d.st = csss_pkg::S_SLEEP;
            end
         end
         csss_pkg::S_SLEEP: begin
            if (WAKE_REQ) begin
               d.st   = csss_pkg::S_WAKE;
               d.load = 1'b1;
               d.tsel = 1'b0;
               d.tgt  = csss_wake_cyc(cur_dec.wake);
            end
         end
         csss_pkg::S_WAKE: begin
            if (!q.load && cif.done) begin
               d.st = csss_pkg::S_RUN;
            end
         end
         default: begin
            d.st = csss_pkg::S_FUSE;
         end
      endcase

      // Register writes
      if (bus_wr) begin
         case (WB_ADR_I)
            csss_pkg::ADR_TRIM: begin
               d.trim = WB_DAT_I[7:0];
            end
            csss_pkg::ADR_CLK_SRC_FIELD: begin
               if (wr_dec.valid) begin
                  d.src = WB_DAT_I[csss_pkg::CLK_SRC_FIELD_SRC_LSB +: 4];
                  d.startup_fuse = WB_DAT_I[csss_pkg::CLK_SRC_FIELD_SUT_LSB +: 2];
                  // A new source while running must settle before execution resumes
                  if (q.st == csss_pkg::S_RUN) begin
                     d.st   = csss_pkg::S_WAKE;
                     d.load = 1'b1;
                     d.tsel = 1'b0;
                     d.tgt  = csss_wake_cyc(wr_dec.wake);
                  end
               end
            end
            csss_pkg::ADR_STAT: begin
               if (WB_DAT_I[csss_pkg::STAT_REJ_BIT]) begin
                  d.rej = 1'b0;
               end
            end
            default: begin
               d.rej = d.rej;
            end
         endcase
      end

      // Rejection flag is set after the clear so a same-cycle event wins
      if (bus_wr && (WB_ADR_I == csss_pkg::ADR_CLK_SRC_FIELD) && !wr_dec.valid) begin
         d.rej = 1'b1;
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge MCLK) begin
      if (RST) begin
         q <= RST_VAL;
      end else if (CE) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign WB_DAT_O    = q.rdat;
   assign WB_ACK_O    = q.ack;
   assign OSC_TRIM    = q.trim;
   assign RC_OSC_SEL  = (q.src == csss_pkg::SRC_RC);
   assign WDT_OSC_SEL = (q.src == csss_pkg::SRC_WDT);
   assign XTAL_EN     = q.src[3];
   // Lowest mode is meant for ceramic resonators only; nothing here can check that
   assign XTAL_MODE   = q.src[3] ? q.src[3:1] : 3'h0;
   assign WDT_OSC_EN  = 1'b1;
   assign DIV8_EN     = q.div8;
   assign CPU_RUN     = (q.st == csss_pkg::S_RUN);

endmodule

// File: pkg/csss_cnt_if.sv
// Handshake between the sequencer and its delay counter
`timescale 1ns/1ps
interface csss_cnt_if #(parameter int W = 15);
   logic         load;
   logic [W-1:0] target;
   logic         tick;
   logic         done;
   logic [W-1:0] count;

   modport ctl (output load, output target, output tick, input done, input count);
   modport cnt (input load, input target, input tick, output done, output count);
endinterface

// File: pkg/csss_pkg.sv
// Shared constants, codes and types of the clock source start-up selector
package csss_pkg;

   // ----------------------------------------------------------------
   // Register map (byte offsets on the Wishbone bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_TRIM  = 8'h00;
   localparam logic [7:0] ADR_CLK_SRC_FIELD  = 8'h04;
   localparam logic [7:0] ADR_STAT  = 8'h08;
   localparam logic [7:0] ADR_COUNT = 8'h0C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CLK_SRC_FIELD_SRC_LSB  = 0;
   localparam int CLK_SRC_FIELD_SUT_LSB  = 4;
   localparam int STAT_RUN_BIT  = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_SLP_BIT  = 2;
   localparam int STAT_REJ_BIT  = 3;
   localparam int STAT_RPD_BIT  = 4;
   localparam int STAT_DIV8_BIT = 5;

   // ----------------------------------------------------------------
   // Values after reset and source codes
   // ----------------------------------------------------------------
   localparam logic [7:0] TRIM_RST = 8'h00;
   localparam logic [3:0] SRC_RST  = 4'h2;
   localparam logic [1:0] SUT_RST  = 2'h2;
   localparam logic [3:0] SRC_RC   = 4'h2;
   localparam logic [3:0] SRC_WDT  = 4'h3;
   localparam logic [1:0] SUT_RSVD = 2'h3;

   // ----------------------------------------------------------------
   // Cycle counts
   // ----------------------------------------------------------------
   localparam int CNT_W        = 15;
   localparam int FUSE_WAIT    = 3;
   localparam int RST_CK_CYC   = 14;
   localparam int WAKE_SHORT   = 6;
   localparam int WAKE_258     = 258;
   localparam int WAKE_1K      = 1024;
   localparam int WAKE_16K     = 16384;
   localparam int RT_SHORT_CYC = 512;
   localparam int RT_LONG_CYC  = 8192;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {S_FUSE, S_RST_RT, S_RST_CK, S_RUN, S_SLEEP, S_WAKE} csss_state_e;
   typedef enum logic [1:0] {W_6, W_258, W_1K, W_16K} csss_wake_e;
   typedef enum logic [1:0] {RT_NONE, RT_SHORT, RT_LONG} csss_rt_e;

   typedef struct packed {
      logic       valid;
      csss_wake_e wake;
      csss_rt_e   rt;
   } csss_dec_s;

endpackage
